// ==== usbrx_host_model.sv ====
// host side model: sends one out data packet per request
// assumes the bench pulses go_in for one cycle and waits for done_out
`timescale 1ns/1ns
`default_nettype none
module usbrx_host_model (
   input  wire logic        clock_in,
   input  wire logic        go_in,
   input  wire logic [11:0] len_in,
   input  wire logic        pid1_in,
   input  wire logic        crc_ok_in,
   output logic             rx_start_out,
   output logic             rx_byte_valid_out,
   output logic [7:0]       rx_byte_out,
   output logic             rx_end_out,
   output logic             rx_crc_ok_out,
   output logic             rx_pid_data1_out,
   output logic             done_out
);
   initial begin
      rx_start_out      = 1'b0;
      rx_byte_valid_out = 1'b0;
      rx_byte_out       = 8'h00;
      rx_end_out        = 1'b0;
      rx_crc_ok_out     = 1'b0;
      rx_pid_data1_out  = 1'b0;
      done_out          = 1'b0;
      forever begin
         @(posedge clock_in);
         if (go_in) begin
            rx_start_out <= 1'b1;
            for (int i = 0; i < len_in; i++) begin
               @(posedge clock_in);
               rx_start_out      <= 1'b0;
               rx_byte_valid_out <= 1'b1;
               rx_byte_out       <= 8'h30 + i[7:0];
            end
            @(posedge clock_in);
            rx_start_out      <= 1'b0;
            rx_byte_valid_out <= 1'b0;
            rx_byte_out       <= ~rx_byte_out;
            rx_end_out        <= 1'b1;
            rx_crc_ok_out     <= crc_ok_in;
            rx_pid_data1_out  <= pid1_in;
            @(posedge clock_in);
            // status levels are meaningless outside the end pulse
            rx_end_out       <= 1'b0;
            rx_crc_ok_out    <= ~rx_crc_ok_out;
            rx_pid_data1_out <= ~rx_pid_data1_out;
            done_out         <= 1'b1;
            @(posedge clock_in);
            done_out <= 1'b0;
         end
      end
   end
endmodule // usbrx_host_model
`default_nettype wire

// ==== usbrx_out_endpoint.sv ====
// receive logic of one usb function out endpoint with its fifo and registers
// assumes the packet engine runs on clock_in and frames each data packet
// Overview of operation
// [RL1] iso bit selects isochronous, else bulk/interrupt
// [RL2] sequence reset: expect DATA0, clear fifo counters
// [RL3] single buffer: unit completion goes empty to full
// [RL4] double buffer: empty, one held, then full
// [RL5] continuous: unit ends at full slot or short
// [RL6] halt answers every out token with stall (here non-iso only; a halted iso endpoint stores the packet)
// [RL7] good packet stored, acked, toggled, interrupt raised (here the interrupt only when the packet completes a unit)
// [RL8] wrong toggle: ack, discard, keep state
// [RL9] no room on non-iso endpoint: nak
// [RL10] oversize non-iso: discard, stall, flag, error irq
// [RL11] crc or stuffing error: no handshake (here a halted non-iso endpoint still answers with stall)
// [RL12] byte read advances pointer one, word two
// [RL13] release frees one held unit
// [RL14] release on read frees unit automatically
// [RL15] iso stored with interrupt, crc error flagged
// [RL16] iso with no room: overflow flag
// [RL17] iso oversize discarded; error flags raise irq
// [RL18] continuous mode only for non-iso endpoints
// [RL19] software checks fill, count, reads, then releases
// [RL20] software never releases during a fifo read
// [RL21] software resets sequence only when empty
// [RL22] software sizes slot as multiple of max packet
// [RL23] count register holds oldest unit length
// [RL24] iso: no handshake, no toggle tracking
`timescale 1ns/1ns
`default_nettype none
module usbrx_out_endpoint
   import usbrx_pkg::*;
#(
   parameter int DEPTH = 512
) (
   input  wire logic                    clock_in,
   input  wire logic                    rst_in,
   input  wire logic                    ce_in,
   input  wire logic [2:0]              reg_addr_in,
   input  wire logic [USBRX_DATA_W-1:0] reg_wdata_in,
   input  wire logic                    reg_wr_in,
   input  wire logic                    reg_rd_in,
   output logic [USBRX_DATA_W-1:0]      reg_rdata_out,
   input  wire logic                    rx_start_in,
   input  wire logic                    rx_byte_valid_in,
   input  wire logic [7:0]              rx_byte_in,
   input  wire logic                    rx_end_in,
   input  wire logic                    rx_crc_ok_in,
   input  wire logic                    rx_stuff_ok_in,
   input  wire logic                    rx_pid_data1_in,
   input  wire logic                    error_irq_enable_in,
   output logic                         hs_ack_out,
   output logic                         hs_nak_out,
   output logic                         hs_stall_out,
   output logic                         out_irq_out,
   output logic                         error_irq_set_out
);
   localparam int PW = $clog2(DEPTH);

   logic [7:0]             mem_reg [DEPTH];
   logic [15:0]            ctrl_reg;
   logic [USBRX_CNT_W-1:0] maxp_reg;
   logic [15:0]            cfg_reg;
   logic                   toggle_reg;
   logic                   ovfl_reg, ovsz_reg, perr_reg;
   logic [1:0]             units_reg;
   logic [USBRX_CNT_W-1:0] cnt0_reg, cnt1_reg;
   logic [PW-1:0]          head_reg, rd_ptr_reg, tail_reg;
   logic [USBRX_CNT_W-1:0] unit_bytes_reg, pkt_cnt_reg, rd_unit_reg;
   logic                   pkt_active_reg, pkt_space_reg, pkt_over_reg;
   logic [USBRX_DATA_W-1:0] rdata_reg;
   logic                   ack_reg, nak_reg, stall_reg, oirq_reg, eirq_reg;

   function automatic logic [1:0] fill_code(input logic [1:0] n, input logic dbl);
      if (n == 2'h0)
         fill_code = USBRX_FILL_EMPTY;
      else if (dbl && n == 2'h1)
         fill_code = USBRX_FILL_ONE;
      else
         fill_code = USBRX_FILL_FULL;
   endfunction

   // register decode
   wire wr_ctrl   = reg_wr_in && reg_addr_in == USBRX_OFS_CTRL;
   wire wr_maxp   = reg_wr_in && reg_addr_in == USBRX_OFS_MAXP;
   wire wr_cfg    = reg_wr_in && reg_addr_in == USBRX_OFS_FIFOCFG;
   wire rd_byte   = reg_rd_in && reg_addr_in == USBRX_OFS_FIFO8;
   wire rd_word   = reg_rd_in && reg_addr_in == USBRX_OFS_FIFO16;
   wire iso       = ctrl_reg[USBRX_B_ISO];                                  // RL1
   wire halt      = ctrl_reg[USBRX_B_HALT];
   wire autorel   = ctrl_reg[USBRX_B_AUTOREL];
   wire dbl       = cfg_reg[USBRX_B_DOUBLE];
   wire cont_eff  = cfg_reg[USBRX_B_CONT] && !iso;                          // RL18
   wire [1:0] cap = dbl ? 2'h2 : 2'h1;
   wire [USBRX_CNT_W-1:0] slot_bytes =
      USBRX_CNT_W'(cfg_reg[USBRX_B_SLOT_HI:USBRX_B_SLOT_LO]) << USBRX_SLOT_SHIFT;
   wire seq_rst   = wr_ctrl && reg_wdata_in[USBRX_B_SEQ_RST];
   wire [1:0] fill = fill_code(units_reg, dbl);

   // packet outcome at end of frame
   wire pkt_end   = rx_end_in && pkt_active_reg;
   wire good_crc  = rx_crc_ok_in && rx_stuff_ok_in;
   wire e_stall   = pkt_end && !iso && halt;                                // RL6
   wire e_silent  = pkt_end && !iso && !halt && !good_crc;                  // RL11
   wire e_over    = pkt_end && !e_stall && !e_silent && pkt_over_reg;       // RL10 RL17
   wire e_full    = pkt_end && !e_stall && !e_silent && !pkt_over_reg && !pkt_space_reg;
   wire e_dup     = pkt_end && !iso && !halt && good_crc && !pkt_over_reg && pkt_space_reg
                    && (rx_pid_data1_in != toggle_reg);                     // RL8
   wire e_store   = pkt_end && !e_stall && !e_silent && !pkt_over_reg && pkt_space_reg
                    && !e_dup;                                              // RL7 RL15
   wire [USBRX_CNT_W-1:0] new_unit = unit_bytes_reg + pkt_cnt_reg;
   wire unit_done = e_store && (!cont_eff || new_unit >= slot_bytes
                    || pkt_cnt_reg < maxp_reg);                             // RL5
   wire e_ovfl    = e_full && iso;                                          // RL16
   wire e_perr    = e_store && iso && !good_crc;                            // RL15

   // fifo read side
   wire [USBRX_CNT_W-1:0] rd_step = rd_word ? USBRX_CNT_W'(2) : USBRX_CNT_W'(1);
   wire [USBRX_CNT_W-1:0] rd_after = rd_unit_reg + rd_step;
   wire auto_pop  = autorel && (rd_byte || rd_word) && units_reg != 2'h0
                    && rd_after >= cnt0_reg;                                // RL14
   wire sw_pop    = wr_ctrl && (reg_wdata_in[USBRX_B_RELEASE] || reg_wdata_in[USBRX_B_FLUSH]);
   wire pop       = (sw_pop || auto_pop) && units_reg != 2'h0;              // RL13
   wire [PW-1:0] next_head = head_reg + PW'(cnt0_reg);
   wire [PW-1:0] rd_p1 = rd_ptr_reg + PW'(1);

   // unit count and count queue
   logic [1:0]             units_next;
   logic [USBRX_CNT_W-1:0] cnt0_next, cnt1_next;
   always_comb begin
      units_next = units_reg + {1'b0, unit_done} - {1'b0, pop};             // RL3 RL4
      cnt0_next  = cnt0_reg;
      cnt1_next  = cnt1_reg;
      if (pop) begin
         cnt0_next = cnt1_reg;                                              // RL23
         if (unit_done && units_reg == 2'h1)
            cnt0_next = new_unit;
         else if (unit_done)
            cnt1_next = new_unit;
      end else if (unit_done) begin
         if (units_reg == 2'h0)
            cnt0_next = new_unit;
         else
            cnt1_next = new_unit;
      end
   end

   // received byte storage
   always_ff @(posedge clock_in) begin
      if (ce_in && rx_byte_valid_in && pkt_active_reg && pkt_space_reg
          && pkt_cnt_reg < maxp_reg)
         mem_reg[tail_reg + PW'(unit_bytes_reg) + PW'(pkt_cnt_reg)] <= rx_byte_in;
   end

   // packet framing
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         pkt_active_reg <= 1'b0;
         pkt_space_reg  <= 1'b0;
         pkt_over_reg   <= 1'b0;
         pkt_cnt_reg    <= '0;
      end else if (ce_in) begin
         if (rx_start_in) begin
            pkt_active_reg <= 1'b1;
            pkt_space_reg  <= units_reg < cap;                              // RL9 RL16
            pkt_over_reg   <= 1'b0;
            pkt_cnt_reg    <= '0;
         end else if (pkt_end) begin
            pkt_active_reg <= 1'b0;
         end else if (rx_byte_valid_in && pkt_active_reg) begin
            if (pkt_cnt_reg >= maxp_reg)
               pkt_over_reg <= 1'b1;                                        // RL10
            else
               pkt_cnt_reg <= pkt_cnt_reg + USBRX_CNT_W'(1);
         end
      end
   end

   // fill state, pointers and toggle
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         units_reg      <= 2'h0;
         cnt0_reg       <= '0;
         cnt1_reg       <= '0;
         head_reg       <= '0;
         rd_ptr_reg     <= '0;
         tail_reg       <= '0;
         unit_bytes_reg <= '0;
         rd_unit_reg    <= '0;
         toggle_reg     <= 1'b0;
      end else if (ce_in) begin
         units_reg <= units_next;
         cnt0_reg  <= cnt0_next;
         cnt1_reg  <= cnt1_next;
         if (seq_rst) begin
            toggle_reg     <= 1'b0;                                         // RL2
            head_reg       <= '0;
            rd_ptr_reg     <= '0;
            tail_reg       <= '0;
            unit_bytes_reg <= '0;
            rd_unit_reg    <= '0;
         end else begin
            if (e_store && !iso)
               toggle_reg <= !toggle_reg;                                   // RL7 RL24
            if (unit_done) begin
               tail_reg       <= tail_reg + PW'(new_unit);
               unit_bytes_reg <= '0;
            end else if (e_store) begin
               unit_bytes_reg <= new_unit;                                  // RL5
            end
            if (pop) begin
               head_reg    <= next_head;
               rd_ptr_reg  <= next_head;
               rd_unit_reg <= '0;
            end else if (rd_byte || rd_word) begin
               rd_ptr_reg  <= rd_ptr_reg + PW'(rd_step);                    // RL12
               rd_unit_reg <= rd_after;
            end
         end
      end
   end

   // software registers and sticky error flags, set wins over clear
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ctrl_reg <= USBRX_RST_WORD;
         maxp_reg <= '0;
         cfg_reg  <= USBRX_RST_WORD;
         ovfl_reg <= 1'b0;
         ovsz_reg <= 1'b0;
         perr_reg <= 1'b0;
      end else if (ce_in) begin
         if (wr_ctrl) begin
            ctrl_reg[USBRX_B_ISO]     <= reg_wdata_in[USBRX_B_ISO];
            ctrl_reg[USBRX_B_HALT]    <= reg_wdata_in[USBRX_B_HALT];
            ctrl_reg[USBRX_B_AUTOREL] <= reg_wdata_in[USBRX_B_AUTOREL];
         end
         if (wr_maxp)
            maxp_reg <= reg_wdata_in[USBRX_CNT_W-1:0];
         if (wr_cfg)
            cfg_reg <= reg_wdata_in;
         if (e_ovfl)
            ovfl_reg <= 1'b1;                                               // RL16
         else if (wr_ctrl && reg_wdata_in[USBRX_B_CLR_OVFL])
            ovfl_reg <= 1'b0;
         if (e_over)
            ovsz_reg <= 1'b1;                                               // RL10 RL17
         else if (wr_ctrl && reg_wdata_in[USBRX_B_CLR_OVSZ])
            ovsz_reg <= 1'b0;
         if (e_perr)
            perr_reg <= 1'b1;                                               // RL15
         else if (wr_ctrl && reg_wdata_in[USBRX_B_CLR_PERR])
            perr_reg <= 1'b0;
      end
   end

   // read data, one cycle after the strobe
   logic [USBRX_DATA_W-1:0] rdata_next;
   always_comb begin
      rdata_next = USBRX_RST_WORD;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            USBRX_OFS_CTRL: begin
               rdata_next[USBRX_B_FILL_HI:USBRX_B_FILL_LO] = fill;
               rdata_next[USBRX_B_OVERFLOW] = ovfl_reg;
               rdata_next[USBRX_B_OVERSIZE] = ovsz_reg;
               rdata_next[USBRX_B_PKTERR]   = perr_reg;
               rdata_next[USBRX_B_ISO]      = iso;
               rdata_next[USBRX_B_HALT]     = halt;
               rdata_next[USBRX_B_AUTOREL]  = autorel;
            end
            USBRX_OFS_MAXP:    rdata_next = USBRX_DATA_W'(maxp_reg);
            USBRX_OFS_COUNT:   rdata_next = USBRX_DATA_W'(cnt0_reg);           // RL23
            USBRX_OFS_FIFOCFG: rdata_next = cfg_reg;
            USBRX_OFS_FIFO8:   rdata_next = {8'h00, mem_reg[rd_ptr_reg]};      // RL12
            USBRX_OFS_FIFO16:  rdata_next = {mem_reg[rd_p1], mem_reg[rd_ptr_reg]};
            default:           rdata_next = USBRX_RST_WORD;
         endcase
      end
   end

   // handshakes and event pulses
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rdata_reg <= USBRX_RST_WORD;
         ack_reg   <= 1'b0;
         nak_reg   <= 1'b0;
         stall_reg <= 1'b0;
         oirq_reg  <= 1'b0;
         eirq_reg  <= 1'b0;
      end else if (ce_in) begin
         rdata_reg <= rdata_next;
         ack_reg   <= !iso && (e_store || e_dup);                           // RL7 RL8 RL24
         nak_reg   <= !iso && e_full;                                       // RL9
         stall_reg <= e_stall || (e_over && !iso);                          // RL6 RL10
         oirq_reg  <= unit_done;                                            // RL7 RL15
         eirq_reg  <= error_irq_enable_in && (e_over || e_ovfl || e_perr);  // RL17
      end
   end

   assign reg_rdata_out     = rdata_reg;
   assign hs_ack_out        = ack_reg;
   assign hs_nak_out        = nak_reg;
   assign hs_stall_out      = stall_reg;
   assign out_irq_out       = oirq_reg;
   assign error_irq_set_out = eirq_reg;
endmodule // usbrx_out_endpoint
`default_nettype wire

// ==== usbrx_out_endpoint_assertions.sv ====
// checker for the usb out endpoint receive block
// assumes it is bound to usbrx_out_endpoint and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module usbrx_out_endpoint_assertions
   import usbrx_pkg::*;
(
   input wire logic                    clock_in,
   input wire logic                    rst_in,
   input wire logic                    ce_in,
   input wire logic [2:0]              reg_addr_in,
   input wire logic [USBRX_DATA_W-1:0] reg_wdata_in,
   input wire logic                    reg_wr_in,
   input wire logic                    reg_rd_in,
   input wire logic [USBRX_DATA_W-1:0] reg_rdata_out,
   input wire logic                    rx_start_in,
   input wire logic                    rx_byte_valid_in,
   input wire logic [7:0]              rx_byte_in,
   input wire logic                    rx_end_in,
   input wire logic                    rx_crc_ok_in,
   input wire logic                    rx_stuff_ok_in,
   input wire logic                    rx_pid_data1_in,
   input wire logic                    error_irq_enable_in,
   input wire logic                    hs_ack_out,
   input wire logic                    hs_nak_out,
   input wire logic                    hs_stall_out,
   input wire logic                    out_irq_out,
   input wire logic                    error_irq_set_out
);
   logic        iso_reg;
   logic        halt_reg;
   logic [10:0] maxp_reg;
   logic [11:0] nbytes_reg;
   logic        hs_any;
   logic        crc_good;
   assign hs_any   = hs_ack_out | hs_nak_out | hs_stall_out;
   assign crc_good = rx_crc_ok_in & rx_stuff_ok_in;
   // shadow of the mode bits and byte count of the packet in flight
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         iso_reg    <= 1'b0;
         halt_reg   <= 1'b0;
         maxp_reg   <= 11'h000;
         nbytes_reg <= 12'h000;
      end else if (ce_in) begin
         if (reg_wr_in && reg_addr_in == USBRX_OFS_CTRL) begin
            iso_reg  <= reg_wdata_in[USBRX_B_ISO];
            halt_reg <= reg_wdata_in[USBRX_B_HALT];
         end
         if (reg_wr_in && reg_addr_in == USBRX_OFS_MAXP) maxp_reg <= reg_wdata_in[10:0];
         if (rx_start_in) nbytes_reg <= 12'h000;
         else if (rx_byte_valid_in) nbytes_reg <= nbytes_reg + 12'h001;
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   chk_one_handshake: assert property ($onehot0({hs_ack_out, hs_nak_out, hs_stall_out}))
      else $error("two handshakes at once");
   chk_halt_stall: assert property (rx_end_in && halt_reg && !iso_reg |=> hs_stall_out)
      else $error("halted endpoint did not stall");
   chk_crc_silent: assert property (rx_end_in && !halt_reg && !iso_reg && !crc_good |=> !hs_any)
      else $error("handshake after damaged packet");
   chk_oversize_stall: assert property (rx_end_in && !iso_reg && crc_good && nbytes_reg > {1'b0, maxp_reg}
      |=> hs_stall_out)
      else $error("oversize packet not stalled");
   chk_iso_silent: assert property (rx_end_in && iso_reg |=> !hs_any ##1 !hs_any)
      else $error("handshake on isochronous endpoint");
   chk_irq_with_ack: assert property (out_irq_out && !iso_reg |-> hs_ack_out && $past(rx_end_in))
      else $error("unit interrupt without ack");
   chk_err_enabled: assert property (error_irq_set_out |-> $past(error_irq_enable_in) && $past(rx_end_in))
      else $error("error interrupt while disabled");
   chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
      else $error("read data outside read cycle");
endmodule // usbrx_out_endpoint_assertions
`default_nettype wire

// ==== usbrx_out_endpoint_bench.sv ====
// self-checking bench for the usb out endpoint receive block
// assumes the host model, the checker and the design package are compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
   $display("BAD %0t value %h expected %h", $time, a, b); end end
module usbrx_out_endpoint_bench;
   import usbrx_pkg::*;
   localparam logic [2:0] HZ = 3'b000, HA = 3'b001, HN = 3'b010, HS = 3'b100;
   logic clock_in = 1'b0, rst_in = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, pid1 = 1'b0, crc_ok = 1'b1;
   logic [2:0] reg_addr = 3'h0, seen = 3'h0;
   logic [15:0] reg_wdata = 16'h0000, rdata, rv;
   logic [11:0] len = 12'h000;
   logic st, bv, en, crc, pd, done, ack, nak, stall, irq, err, irq_seen, err_seen;
   logic [7:0] bt;
   logic irq_en = 1'b1;
   int errors = 0, compares = 0, cyc = 0;
   initial forever #4 clock_in = ~clock_in;
   usbrx_host_model i_usbrx_host_model (.clock_in(clock_in), .go_in(go), .len_in(len), .pid1_in(pid1),
      .crc_ok_in(crc_ok), .rx_start_out(st), .rx_byte_valid_out(bv), .rx_byte_out(bt), .rx_end_out(en),
      .rx_crc_ok_out(crc), .rx_pid_data1_out(pd), .done_out(done));
   usbrx_out_endpoint i_usbrx_out_endpoint (.clock_in(clock_in), .rst_in(rst_in), .ce_in(1'b1),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_rdata_out(rdata), .rx_start_in(st), .rx_byte_valid_in(bv), .rx_byte_in(bt), .rx_end_in(en),
      .rx_crc_ok_in(crc), .rx_stuff_ok_in(crc), .rx_pid_data1_in(pd), .error_irq_enable_in(irq_en),
      .hs_ack_out(ack), .hs_nak_out(nak), .hs_stall_out(stall), .out_irq_out(irq), .error_irq_set_out(err));
   always @(posedge clock_in) begin
      seen     <= seen | {stall, nak, ack};
      irq_seen <= irq_seen | irq;
      err_seen <= err_seen | err;
      cyc++;
      if (cyc == 20000) begin errors++; tally_and_finish(); end
   end
   task automatic tally_and_finish();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clock_in); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clock_in); reg_wr <= 1'b0;
   endtask
   task automatic rc(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge clock_in); reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clock_in); reg_rd <= 1'b0;
      #1 rv = rdata;
      `CHK(rv & m, e)
   endtask
   task automatic pkt(input logic [11:0] n, input logic p, c, input logic [2:0] hs, input logic i, r);
      int k;
      @(posedge clock_in); len <= n; pid1 <= p; crc_ok <= c; go <= 1'b1;
      #1 seen = HZ; irq_seen = 1'b0; err_seen = 1'b0; k = 0;
      @(posedge clock_in); go <= 1'b0;
      while (done !== 1'b1 && k < 100) begin @(posedge clock_in); #1 k++; end
      if (k >= 100) errors++;
      repeat (3) @(posedge clock_in);
      #1 `CHK({seen, irq_seen, err_seen}, {hs, i, r})
   endtask
   task automatic t_single();
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0000);
      pkt(4, 0, 1, HA, 1, 0);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0003);
      rc(USBRX_OFS_COUNT, 16'h07FF, 16'h0004);
      pkt(4, 1, 1, HN, 0, 0);
      rc(USBRX_OFS_FIFO8, 16'h00FF, 16'h0030);
      rc(USBRX_OFS_FIFO16, 16'hFFFF, 16'h3231);
      rc(USBRX_OFS_FIFO8, 16'h00FF, 16'h0033);
      wr(USBRX_OFS_CTRL, 16'h0020);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0000);
      $display("single buffer test done");
   endtask
   task automatic t_errors();
      pkt(2, 0, 1, HA, 0, 0);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0000);
      pkt(2, 1, 1, HA, 1, 0);
      wr(USBRX_OFS_CTRL, 16'h0020);
      pkt(2, 0, 0, HZ, 0, 0);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0000);
      pkt(9, 0, 1, HS, 0, 1);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0008);
      wr(USBRX_OFS_CTRL, 16'h1080);
      pkt(2, 0, 1, HS, 0, 0);
      wr(USBRX_OFS_CTRL, 16'h0000);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0000);
      $display("toggle and error test done");
   endtask
   task automatic t_double();
      wr(USBRX_OFS_FIFOCFG, 16'h0050);
      pkt(3, 0, 1, HA, 1, 0);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0002);
      pkt(5, 1, 1, HA, 1, 0);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0003);
      pkt(2, 0, 1, HN, 0, 0);
      rc(USBRX_OFS_COUNT, 16'h07FF, 16'h0003);
      wr(USBRX_OFS_CTRL, 16'h0020);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0002);
      rc(USBRX_OFS_COUNT, 16'h07FF, 16'h0005);
      wr(USBRX_OFS_CTRL, 16'h0020);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0000);
      pkt(1, 0, 1, HA, 1, 0);
      wr(USBRX_OFS_CTRL, 16'h0020);
      wr(USBRX_OFS_CTRL, 16'h0200);
      pkt(1, 0, 1, HA, 1, 0);
      rc(USBRX_OFS_FIFO8, 16'h00FF, 16'h0030);
      wr(USBRX_OFS_CTRL, 16'h0020);
      wr(USBRX_OFS_CTRL, 16'h2000);
      pkt(2, 1, 1, HA, 1, 0);
      rc(USBRX_OFS_FIFO16, 16'hFFFF, 16'h3130);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0000);
      $display("double buffer test done");
   endtask
   task automatic t_cont();
      wr(USBRX_OFS_FIFOCFG, 16'h0060);
      wr(USBRX_OFS_CTRL, 16'h0000);
      pkt(8, 0, 1, HA, 0, 0);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0000);
      pkt(3, 1, 1, HA, 1, 0);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0003);
      rc(USBRX_OFS_COUNT, 16'h07FF, 16'h000B);
      wr(USBRX_OFS_CTRL, 16'h0400);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0000);
      $display("continuous test done");
   endtask
   task automatic t_iso();
      wr(USBRX_OFS_FIFOCFG, 16'h0060);
      wr(USBRX_OFS_CTRL, 16'h0800);
      pkt(8, 0, 0, HZ, 1, 1);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0013);
      pkt(2, 0, 1, HZ, 0, 1);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0017);
      wr(USBRX_OFS_CTRL, 16'h0820);
      pkt(9, 1, 1, HZ, 0, 1);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h001C);
      rc(3'h7, 16'hFFFF, 16'h0000);
      wr(USBRX_OFS_CTRL, 16'h09C0);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0000);
      @(posedge clock_in) irq_en <= 1'b0;
      pkt(9, 1, 1, HZ, 0, 0);
      rc(USBRX_OFS_CTRL, 16'h001F, 16'h0008);
      $display("isochronous test done");
   endtask
   initial begin
      repeat (10) @(posedge clock_in);
      rst_in <= 1'b0;
      wr(USBRX_OFS_MAXP, 16'h0008);
      wr(USBRX_OFS_FIFOCFG, 16'h0040);
      t_single();
      t_errors();
      t_double();
      t_cont();
      t_iso();
      tally_and_finish();
   end
endmodule // usbrx_out_endpoint_bench
bind usbrx_out_endpoint usbrx_out_endpoint_assertions i_usbrx_out_endpoint_assertions (.clock_in(clock_in),
   .rst_in(rst_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .rx_start_in(rx_start_in),
   .rx_byte_valid_in(rx_byte_valid_in), .rx_byte_in(rx_byte_in), .rx_end_in(rx_end_in), .rx_crc_ok_in(rx_crc_ok_in),
   .rx_stuff_ok_in(rx_stuff_ok_in), .rx_pid_data1_in(rx_pid_data1_in), .error_irq_enable_in(error_irq_enable_in),
   .hs_ack_out(hs_ack_out), .hs_nak_out(hs_nak_out), .hs_stall_out(hs_stall_out), .out_irq_out(out_irq_out),
   .error_irq_set_out(error_irq_set_out));
`default_nettype wire

// ==== usbrx_pkg.sv ====
// constants for the usb out endpoint receive block
// assumes one 16-bit register port and a packet engine on the same clock
package usbrx_pkg;
   // register word offsets
   localparam logic [2:0] USBRX_OFS_CTRL     = 3'h0;
   localparam logic [2:0] USBRX_OFS_MAXP     = 3'h1;
   localparam logic [2:0] USBRX_OFS_COUNT    = 3'h2;
   localparam logic [2:0] USBRX_OFS_FIFOCFG  = 3'h3;
   localparam logic [2:0] USBRX_OFS_FIFO8    = 3'h4;
   localparam logic [2:0] USBRX_OFS_FIFO16   = 3'h5;
   // control and status bit positions
   localparam int USBRX_B_FILL_LO   = 0;
   localparam int USBRX_B_FILL_HI   = 1;
   localparam int USBRX_B_OVERFLOW  = 2;
   localparam int USBRX_B_OVERSIZE  = 3;
   localparam int USBRX_B_PKTERR    = 4;
   localparam int USBRX_B_RELEASE   = 5;
   localparam int USBRX_B_CLR_OVFL  = 6;
   localparam int USBRX_B_CLR_OVSZ  = 7;
   localparam int USBRX_B_CLR_PERR  = 8;
   localparam int USBRX_B_SEQ_RST   = 9;
   localparam int USBRX_B_FLUSH     = 10;
   localparam int USBRX_B_ISO       = 11;
   localparam int USBRX_B_HALT      = 12;
   localparam int USBRX_B_AUTOREL   = 13;
   // fifo configuration bit positions
   localparam int USBRX_B_DOUBLE    = 4;
   localparam int USBRX_B_CONT      = 5;
   localparam int USBRX_B_SLOT_LO   = 6;
   localparam int USBRX_B_SLOT_HI   = 9;
   localparam int USBRX_SLOT_SHIFT  = 6;
   // widths and fill codes
   localparam int USBRX_CNT_W       = 11;
   localparam int USBRX_DATA_W      = 16;
   localparam logic [1:0] USBRX_FILL_EMPTY = 2'h0;
   localparam logic [1:0] USBRX_FILL_ONE   = 2'h2;
   localparam logic [1:0] USBRX_FILL_FULL  = 2'h3;
   localparam logic [15:0] USBRX_RST_WORD  = 16'h0000;
endpackage
